// ---- tb/arbiter_core_model.sv ----
`timescale 1ns/1ps
module arbiter_core_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // selection offered by the priority bank
  input  wire logic       sel_valid_i,
  input  wire logic [4:0] sel_slot_i,
  input  wire logic [2:0] sel_level_i,
  // request last taken for service
  output logic [4:0]      taken_slot_o,
  output logic [2:0]      taken_level_o
);
  // the core vectors to the offered request; a level of zero is never serviced
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      taken_slot_o  <= 5'h00;
      taken_level_o <= 3'h0;
    end else if (sel_valid_i && sel_level_i != 3'h0) begin
      taken_slot_o  <= sel_slot_i;
      taken_level_o <= sel_level_i;
    end
  end
endmodule

// ---- tb/interrupt_priority_fields_bank_tb.sv ----
`timescale 1ns/1ps
module interrupt_priority_fields_bank_tb;
  // stimulus driven by the bench
  logic                   clk_i   = 1'b0;
  logic                   reset_i = 1'b1;
  logic                   awvalid = 1'b0;
  logic                   wvalid  = 1'b0;
  logic                   arvalid = 1'b0;
  logic [31:0]            awaddr  = 32'h0;
  logic [31:0]            wdata   = 32'h0;
  logic [31:0]            araddr  = 32'h0;
  logic [23:0]            flags   = 24'h0;
  // design and partner outputs
  logic                   awready, wready, bvalid, arready, rvalid, sel_valid;
  logic [1:0]             bresp, rresp;
  logic [31:0]            rdata;
  logic [4:0]             sel_slot, taken_slot;
  logic [2:0]             sel_level, taken_level;
  prio_bank_pkg::levels_s levels;
  logic [5:0][15:0]       words;
  int                     errors  = 0;
  int                     checked = 0;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  interrupt_priority_fields_bank dut (
    .clk_i(clk_i), .reset_i(reset_i),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(1'b1), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .source_flag_i(flags), .levels_o(levels),
    .sel_valid_o(sel_valid), .sel_slot_o(sel_slot), .sel_level_o(sel_level));

  arbiter_core_model core (
    .clk_i(clk_i), .reset_i(reset_i), .sel_valid_i(sel_valid), .sel_slot_i(sel_slot),
    .sel_level_i(sel_level), .taken_slot_o(taken_slot), .taken_level_o(taken_level));

  // verdict and end of run
  task stop_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // value comparison
  task chk(input logic [65:0] got, input logic [65:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task hang;
    errors++;
    $display("BAD %0t bus answer missing", $time);
    stop_test();
  endtask

  // one write, address and data offered together; bready is always high
  // handshakes are judged on settled values half a cycle before the taking edge
  task wrc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int         n;
    logic       aw_go;
    logic       w_go;
    logic       seen;
    logic [1:0] resp;
    n    = 0;
    seen = 1'b0;
    resp = 2'h0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(negedge clk_i);
      aw_go = awvalid && awready;
      w_go  = wvalid && wready;
      seen  = bvalid;
      resp  = bresp;
      @(posedge clk_i);
      n++;
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end while (!seen && n < 50);
    if (!seen) hang();
    chk(resp, er, "write response");
  endtask

  // one read; rready is always high
  task rdc(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er, input string w);
    int          n;
    logic        ar_go;
    logic        seen;
    logic [31:0] data;
    logic [1:0]  resp;
    n    = 0;
    seen = 1'b0;
    data = 32'h0;
    resp = 2'h0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk_i);
      ar_go = arvalid && arready;
      seen  = rvalid;
      data  = rdata;
      resp  = rresp;
      @(posedge clk_i);
      n++;
      if (ar_go) arvalid <= 1'b0;
    end while (!seen && n < 50);
    if (!seen) hang();
    chk(data, ed, w);
    chk(resp, er, w);
  endtask

  // expected source levels from the six stored words
  function automatic prio_bank_pkg::levels_s exp_lv(input logic [5:0][15:0] w);
    exp_lv = {w[5][14:12], w[5][10:8], w[5][6:4], w[5][2:0],
              w[4][14:12], w[4][10:8], w[4][6:4], w[4][2:0],
              w[3][14:12], w[3][10:8], w[3][6:4], w[3][2:0],
              w[2][14:12], w[2][6:4], w[2][2:0],
              w[1][10:8], w[1][6:4], w[1][2:0],
              w[0][14:12], w[0][10:8], w[0][6:4], w[0][2:0]};
  endfunction

  // program register 2, enables and flags, then check the selection
  task arb(input logic [15:0] w0, input logic [23:0] en, input logic [23:0] fl,
           input logic [8:0] e);
    wrc(32'h0, {16'h0, w0}, prio_bank_pkg::RESP_OKAY);
    wrc(prio_bank_pkg::ADDR_ENABLE, {8'h0, en}, prio_bank_pkg::RESP_OKAY);
    flags <= fl;
    repeat (3) @(posedge clk_i);
    if (e[8]) begin
      chk({sel_valid, sel_slot, sel_level}, e, "selection");
      chk({taken_slot, taken_level}, e[7:0], "serviced");
      rdc(prio_bank_pkg::ADDR_SELECT, {23'h0, e}, prio_bank_pkg::RESP_OKAY, "select word");
    end else
      chk(sel_valid, 1'b0, "no selection");
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    chk(levels, {22{3'h4}}, "reset levels");
    for (int i = 0; i < 6; i++)
      rdc(4 * i, {16'h0, prio_bank_pkg::PRIO_RST[i]}, 2'h0, "reset word");
    rdc(prio_bank_pkg::ADDR_ENABLE, 32'h0, 2'h0, "reset enable");
    for (int i = 0; i < 6; i++) begin
      words[i] = 16'(16'hfedc ^ (16'h1111 * i)) & prio_bank_pkg::PRIO_MASK[i];
      wrc(4 * i, {16'hffff, 16'(16'hfedc ^ (16'h1111 * i))}, 2'h0);
    end
    for (int i = 0; i < 6; i++)
      rdc(4 * i, {16'h0, words[i]}, 2'h0, "readback");
    chk(levels, exp_lv(words), "field map");
    rdc(32'h24, 32'h0, prio_bank_pkg::RESP_SLVERR, "unmapped read");
    wrc(32'h24, 32'hffff, prio_bank_pkg::RESP_SLVERR);
    arb(16'h0071, 24'hffffff, 24'h000003, {1'b1, 5'h01, 3'h7});
    arb(16'h0001, 24'hffffff, 24'h000003, {1'b1, 5'h00, 3'h1});
    arb(16'h0032, 24'hffffff, 24'h000003, {1'b1, 5'h01, 3'h3});
    arb(16'h0033, 24'hffffff, 24'h000003, {1'b1, 5'h00, 3'h3});
    arb(16'h0033, 24'hfffffe, 24'h000003, {1'b1, 5'h01, 3'h3});
    arb(16'h0071, 24'h000000, 24'h000003, 9'h000);
    arb(16'h0000, 24'hffffff, 24'h000003, 9'h000);
    stop_test();
  end
endmodule

// ---- verilog/interrupt_priority_fields_bank.sv ----
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module interrupt_priority_fields_bank (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  // axi4-lite write address
  input  wire logic                    s_axi_awvalid_i,
  output logic                         s_axi_awready_o,
  input  wire logic [31:0]             s_axi_awaddr_i,
  input  wire logic [2:0]              s_axi_awprot_i,
  // axi4-lite write data
  input  wire logic                    s_axi_wvalid_i,
  output logic                         s_axi_wready_o,
  input  wire logic [31:0]             s_axi_wdata_i,
  input  wire logic [3:0]              s_axi_wstrb_i,
  // axi4-lite write response
  output logic                         s_axi_bvalid_o,
  input  wire logic                    s_axi_bready_i,
  output logic [1:0]                   s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic                    s_axi_arvalid_i,
  output logic                         s_axi_arready_o,
  input  wire logic [31:0]             s_axi_araddr_i,
  input  wire logic [2:0]              s_axi_arprot_i,
  // axi4-lite read data
  output logic                         s_axi_rvalid_o,
  input  wire logic                    s_axi_rready_i,
  output logic [31:0]                  s_axi_rdata_o,
  output logic [1:0]                   s_axi_rresp_o,
  // peripheral request flags, one per slot
  input  wire logic [23:0]             source_flag_i,
  // arbitration side
  output prio_bank_pkg::levels_s       levels_o,
  output logic                         sel_valid_o,
  output logic [4:0]                   sel_slot_o,
  output logic [2:0]                   sel_level_o
);

  prio_bank_pkg::state_s state_r;
  prio_bank_pkg::state_s state_nxt;

  // level held for one slot
  function automatic logic [2:0] level_of(input logic [5:0][15:0] prio, input logic [4:0] slot);
    logic [15:0] word;
    word     = prio[slot[4:2]];
    level_of = word[slot[1:0]*prio_bank_pkg::FIELD_STRIDE +: prio_bank_pkg::FIELD_W];
  endfunction

  // register index from a byte address, 4'hf when unmapped
  function automatic logic [3:0] reg_index(input logic [31:0] addr);
    if (addr > prio_bank_pkg::ADDR_LAST || addr[1:0] != 2'h0) begin
      reg_index = 4'hf;
    end else begin
      reg_index = addr[5:2];
    end
  endfunction

  // merge write data into a word under the byte strobes
  function automatic logic [31:0] strobe_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    strobe_merge = res;
  endfunction

  logic [23:0] nonzero;
  logic [23:0] presented;
  logic [23:0] lvl_max_set;
  logic [23:0] lvl_min_set;
  logic        aw_take;
  logic        w_take;
  logic        do_write;
  logic [3:0]  wr_idx;
  logic [3:0]  rd_idx;
  logic [2:0]  best_level;
  logic [4:0]  best_slot;
  logic [15:0] wdata_low;

  // per-slot level decode
  always_comb begin
    for (int s = 0; s < prio_bank_pkg::NUM_SLOTS; s++) begin
      nonzero[s]     = level_of(state_r.prio, 5'(s)) != prio_bank_pkg::LEVEL_OFF;
      lvl_max_set[s] = level_of(state_r.prio, 5'(s)) == prio_bank_pkg::LEVEL_MAX;
      lvl_min_set[s] = level_of(state_r.prio, 5'(s)) == prio_bank_pkg::LEVEL_MIN;
    end
    presented = source_flag_i & state_r.enable & nonzero & prio_bank_pkg::SLOT_MASK;
  end

  // highest level wins, lowest slot breaks a tie
  always_comb begin
    best_level = prio_bank_pkg::LEVEL_OFF;
    best_slot  = 5'h00;
    for (int s = 0; s < prio_bank_pkg::NUM_SLOTS; s++) begin
      if (presented[s] && level_of(state_r.prio, 5'(s)) > best_level) begin
        best_level = level_of(state_r.prio, 5'(s));
        best_slot  = 5'(s);
      end
    end
  end

  // bus handshakes
  assign aw_take   = s_axi_awvalid_i && s_axi_awready_o;
  assign w_take    = s_axi_wvalid_i && s_axi_wready_o;
  assign do_write  = state_r.aw_held && state_r.w_held && !state_r.bvalid;
  assign wr_idx    = reg_index(state_r.aw_addr);
  assign rd_idx    = reg_index(s_axi_araddr_i);
  assign wdata_low = state_r.wdata[15:0];

  // next state
  always_comb begin
    state_nxt = state_r;
    if (aw_take) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.aw_addr = s_axi_awaddr_i;
    end
    if (w_take) begin
      state_nxt.w_held = 1'b1;
      state_nxt.wdata  = s_axi_wdata_i;
      state_nxt.wstrb  = s_axi_wstrb_i;
    end
    if (state_r.bvalid && s_axi_bready_i) begin
      state_nxt.bvalid = 1'b0;
    end
    if (do_write) begin
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held  = 1'b0;
      state_nxt.bvalid  = 1'b1;
      state_nxt.bresp   = prio_bank_pkg::RESP_OKAY;
      if (wr_idx < 4'(prio_bank_pkg::NUM_PRIO_REGS)) begin
        state_nxt.prio[wr_idx[2:0]] = 16'(strobe_merge(32'(state_r.prio[wr_idx[2:0]]),
                                      state_r.wdata, state_r.wstrb))
                                      & prio_bank_pkg::PRIO_MASK[wr_idx[2:0]];
      end else if (wr_idx == 4'h6) begin
        state_nxt.enable = 24'(strobe_merge(32'(state_r.enable), state_r.wdata, state_r.wstrb))
                           & prio_bank_pkg::SLOT_MASK;
      end else if (wr_idx == 4'hf) begin
        state_nxt.bresp = prio_bank_pkg::RESP_SLVERR;
      end
    end
    if (state_r.rvalid && s_axi_rready_i) begin
      state_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp  = prio_bank_pkg::RESP_OKAY;
      state_nxt.rdata  = 32'h0000_0000;
      if (rd_idx < 4'(prio_bank_pkg::NUM_PRIO_REGS)) begin
        state_nxt.rdata = {16'h0000, state_r.prio[rd_idx[2:0]]};
      end else if (rd_idx == 4'h6) begin
        state_nxt.rdata = {8'h00, state_r.enable};
      end else if (rd_idx == 4'h7) begin
        state_nxt.rdata = {8'h00, presented};
      end else if (rd_idx == 4'h8) begin
        state_nxt.rdata = {23'h0, state_r.sel_valid, state_r.sel_slot, state_r.sel_level};
      end else begin
        state_nxt.rresp = prio_bank_pkg::RESP_SLVERR;
      end
    end
    state_nxt.sel_valid = presented != '0;
    state_nxt.sel_slot  = best_slot;
    state_nxt.sel_level = best_level;
  end

  // state register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= prio_bank_pkg::STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // bus outputs
  assign s_axi_awready_o = !state_r.aw_held && !state_r.bvalid;
  assign s_axi_wready_o  = !state_r.w_held && !state_r.bvalid;
  assign s_axi_arready_o = !state_r.rvalid;
  assign s_axi_bvalid_o  = state_r.bvalid;
  assign s_axi_bresp_o   = state_r.bresp;
  assign s_axi_rvalid_o  = state_r.rvalid;
  assign s_axi_rdata_o   = state_r.rdata;
  assign s_axi_rresp_o   = state_r.rresp;

  // arbitration outputs
  assign sel_valid_o = state_r.sel_valid;
  assign sel_slot_o  = state_r.sel_slot;
  assign sel_level_o = state_r.sel_level;

  // level fields unpacked from the priority words
  assign levels_o.uart_one_receive_level  = state_r.prio[0][14:12];
  assign levels_o.spi_one_event_level     = state_r.prio[0][10:8];
  assign levels_o.spi_one_error_level     = state_r.prio[0][6:4];
  assign levels_o.timer_three_level       = state_r.prio[0][2:0];
  assign levels_o.dma_one_done_level      = state_r.prio[1][10:8];
  assign levels_o.adc_one_done_level      = state_r.prio[1][6:4];
  assign levels_o.uart_one_transmit_level = state_r.prio[1][2:0];
  assign levels_o.change_notify_level     = state_r.prio[2][14:12];
  assign levels_o.i2c_one_master_level    = state_r.prio[2][6:4];
  assign levels_o.i2c_one_slave_level     = state_r.prio[2][2:0];
  assign levels_o.capture_eight_level     = state_r.prio[3][14:12];
  assign levels_o.capture_seven_level     = state_r.prio[3][10:8];
  assign levels_o.adc_two_done_level      = state_r.prio[3][6:4];
  assign levels_o.external_one_level      = state_r.prio[3][2:0];
  assign levels_o.timer_four_level        = state_r.prio[4][14:12];
  assign levels_o.compare_four_level      = state_r.prio[4][10:8];
  assign levels_o.compare_three_level     = state_r.prio[4][6:4];
  assign levels_o.dma_two_done_level      = state_r.prio[4][2:0];
  assign levels_o.uart_two_transmit_level = state_r.prio[5][14:12];
  assign levels_o.uart_two_receive_level  = state_r.prio[5][10:8];
  assign levels_o.external_two_level      = state_r.prio[5][6:4];
  assign levels_o.timer_five_level        = state_r.prio[5][2:0];

  // checks on the level bank and the selection
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_reset_levels: assert property ($fell(reset_i) |-> state_r.prio == prio_bank_pkg::PRIO_RST)
    else $error("priority fields not at level 4 after reset");
  a_unimpl_zero: assert property (s_axi_rvalid_o && s_axi_rdata_o[31:16] == 16'h0 |-> 1'b1 ##0
      (state_r.prio & ~prio_bank_pkg::PRIO_MASK) == '0)
    else $error("unimplemented priority bit set");
  a_write_read: assert property (do_write && wr_idx == 4'h0 && state_r.wstrb == 4'hf |=>
      state_r.prio[0] == ($past(wdata_low) & prio_bank_pkg::PRIO_MASK[0]) ##1
      state_r.prio[0] == $past(state_r.prio[0]) || $past(do_write))
    else $error("priority word does not hold the written value");
  a_disabled_quiet: assert property ((source_flag_i & nonzero) == '0 |=> !sel_valid_o)
    else $error("source with code 000 presented for service");
  a_enable_gate: assert property ((source_flag_i & state_r.enable) == '0 |=> !sel_valid_o)
    else $error("source presented while its enable is clear");
  a_top_level: assert property ((presented & lvl_max_set) != '0 |=>
      sel_valid_o && sel_level_o == 3'h7)
    else $error("level 7 source not selected");
  a_low_level: assert property (presented != '0 && (presented & ~lvl_min_set) == '0 |=>
      sel_level_o == 3'h1)
    else $error("lone level 1 sources not selected at level 1");
  a_sel_present: assert property (presented != '0 |=> sel_valid_o && sel_level_o != 3'h0
      && sel_level_o == level_of(state_r.prio, sel_slot_o) || $changed(state_r.prio))
    else $error("selection does not follow pending sources");
  a_field_map: assert property (levels_o.uart_one_receive_level == state_r.prio[0][14:12]
      && levels_o.timer_five_level == state_r.prio[5][2:0])
    else $error("level fields misplaced");

  c_write_prio: cover property (do_write && wr_idx < 4'h6);
  c_read_slverr: cover property (s_axi_rvalid_o && s_axi_rresp_o == prio_bank_pkg::RESP_SLVERR);
  c_sel_top: cover property (sel_valid_o && sel_level_o == 3'h7);
  c_two_pending: cover property ($countones(presented) > 1);

endmodule

// ---- verilog/prio_bank_pkg.sv ----
package prio_bank_pkg;

  // register geometry
  localparam int          NUM_PRIO_REGS = 6;
  localparam int          NUM_SLOTS     = 24;
  localparam int          FIELD_W       = 3;
  localparam int          FIELD_STRIDE  = 4;

  // byte addresses of the register map
  localparam logic [31:0] ADDR_PRIO_BASE = 32'h0000_0000;
  localparam logic [31:0] ADDR_ENABLE    = 32'h0000_0018;
  localparam logic [31:0] ADDR_PRESENTED = 32'h0000_001c;
  localparam logic [31:0] ADDR_SELECT    = 32'h0000_0020;
  localparam logic [31:0] ADDR_LAST      = 32'h0000_0020;

  // implemented bits and reset value of each priority word (index 0 is register 2)
  localparam logic [5:0][15:0] PRIO_MASK = {16'h7777, 16'h7777, 16'h7777,
                                            16'h7077, 16'h0777, 16'h7777};
  localparam logic [5:0][15:0] PRIO_RST  = {16'h4444, 16'h4444, 16'h4444,
                                            16'h4044, 16'h0444, 16'h4444};
  // slots that carry a real source
  localparam logic [23:0]      SLOT_MASK = 24'hfffb7f;
  localparam logic [23:0]      ENABLE_RST = 24'h00_0000;

  // level codes
  localparam logic [2:0]  LEVEL_OFF = 3'h0;
  localparam logic [2:0]  LEVEL_MIN = 3'h1;
  localparam logic [2:0]  LEVEL_MAX = 3'h7;

  // bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // level of every source, exported to the arbiter
  typedef struct packed {
    logic [2:0] uart_two_transmit_level;
    logic [2:0] uart_two_receive_level;
    logic [2:0] external_two_level;
    logic [2:0] timer_five_level;
    logic [2:0] timer_four_level;
    logic [2:0] compare_four_level;
    logic [2:0] compare_three_level;
    logic [2:0] dma_two_done_level;
    logic [2:0] capture_eight_level;
    logic [2:0] capture_seven_level;
    logic [2:0] adc_two_done_level;
    logic [2:0] external_one_level;
    logic [2:0] change_notify_level;
    logic [2:0] i2c_one_master_level;
    logic [2:0] i2c_one_slave_level;
    logic [2:0] dma_one_done_level;
    logic [2:0] adc_one_done_level;
    logic [2:0] uart_one_transmit_level;
    logic [2:0] uart_one_receive_level;
    logic [2:0] spi_one_event_level;
    logic [2:0] spi_one_error_level;
    logic [2:0] timer_three_level;
  } levels_s;

  // complete state of the block
  typedef struct packed {
    logic [5:0][15:0] prio;
    logic [23:0]      enable;
    logic             aw_held;
    logic [31:0]      aw_addr;
    logic             w_held;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             sel_valid;
    logic [4:0]       sel_slot;
    logic [2:0]       sel_level;
  } state_s;

  localparam state_s STATE_RST = '{prio: PRIO_RST, enable: ENABLE_RST, default: '0};

endpackage
